// File: rtl/pdcu_pkg.sv
/*
 * Constants and types for the packed decimal convert unit: opcodes, register
 * offsets, the command start bit position, sign and character encodings, state codes.
 * Assumes a 32-bit AHB-Lite register bus and a byte-wide memory path.
 */
package pdcu_pkg;

	// instruction opcodes
	localparam logic [7:0] OP_SHIFT_ROUND = 8'hF8;
	localparam logic [7:0] OP_CMP_SHARED  = 8'h35;
	localparam logic [7:0] OP_CMP_TWO     = 8'h37;
	localparam logic [7:0] OP_L2P         = 8'hF9;
	localparam logic [7:0] OP_P2L         = 8'h36;
	localparam logic [7:0] OP_P2LS        = 8'h08;
	localparam logic [7:0] OP_P2T         = 8'h24;

	// register byte offsets
	localparam logic [7:0] OFS_CMD    = 8'h00;
	localparam logic [7:0] OFS_OPND   = 8'h04;
	localparam logic [7:0] OFS_LENS   = 8'h08;
	localparam logic [7:0] OFS_ADDR1  = 8'h0C;
	localparam logic [7:0] OFS_ADDR2  = 8'h10;
	localparam logic [7:0] OFS_ROUND  = 8'h14;
	localparam logic [7:0] OFS_STATUS = 8'h18;
	localparam logic [7:0] OFS_R0     = 8'h1C;
	localparam logic [7:0] OFS_R1     = 8'h20;
	localparam logic [7:0] OFS_R2     = 8'h24;
	localparam logic [7:0] OFS_R3     = 8'h28;

	// field positions
	localparam int CMD_START_BIT = 8;

	// string limits and iteration counts
	localparam logic [15:0] STR_LEN_LIMIT = 16'h001F;
	localparam logic [5:0]  DABBLE_STEPS  = 6'h20;
	localparam logic [5:0]  P2L_STEPS     = 6'h20;
	localparam logic [5:0]  LONG_BYTES    = 6'h04;

	// sign nibbles and characters
	localparam logic [3:0] SIGN_POS     = 4'hC;
	localparam logic [3:0] SIGN_NEG     = 4'hD;
	localparam logic [3:0] SIGN_NEG_ALT = 4'hB;
	localparam logic [7:0] ASCII_PLUS   = 8'h2B;
	localparam logic [7:0] ASCII_MINUS  = 8'h2D;
	localparam logic [7:0] ASCII_ZERO   = 8'h30;

	localparam logic [31:0] WORD_RESET = 32'h0000_0000;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_CHECK = 3'b001,
		ST_LOAD1 = 3'b010,
		ST_LOAD2 = 3'b011,
		ST_CONV  = 3'b100,
		ST_EXEC  = 3'b101,
		ST_STORE = 3'b110
	} pdcu_state_t;

	typedef enum logic [1:0] {
		SK_PACKED = 2'b00,
		SK_LSEP   = 2'b01,
		SK_LONG   = 2'b10
	} pdcu_store_t;

endpackage : pdcu_pkg

// File: rtl/pdcu_unit.sv
/*
 * Packed decimal convert unit: AHB-Lite register slave plus a sequencer that
 * reads decimal strings byte by byte, computes, and writes results back.
 * Assumes a byte memory path that answers a held request with a one-cycle ack,
 * read data valid in the ack cycle.
 */
`timescale 1ns/100ps

module pdcu_unit #(
	parameter int MAX_STR_LEN = 31
) (
	// clock and reset
	input  wire logic        CLK_I,
	input  wire logic        RST_N_I,
	// ahb-lite slave
	input  wire logic        HSEL_I,
	input  wire logic [31:0] HADDR_I,
	input  wire logic [1:0]  HTRANS_I,
	input  wire logic        HWRITE_I,
	input  wire logic [2:0]  HSIZE_I,
	input  wire logic [31:0] HWDATA_I,
	input  wire logic        HREADY_I,
	output logic      [31:0] HRDATA_O,
	output logic             HREADYOUT_O,
	output logic             HRESP_O,
	// byte memory path
	output logic             MEM_REQ_O,
	output logic             MEM_WE_O,
	output logic      [31:0] MEM_ADDR_O,
	output logic      [7:0]  MEM_WDATA_O,
	input  wire logic [7:0]  MEM_RDATA_I,
	input  wire logic        MEM_ACK_I,
	// status
	output logic             BUSY_O,
	output logic             DONE_O,
	output logic             RSVD_ABORT_O,
	output logic             OVERFLOW_O
);

	if (MAX_STR_LEN < 1 || MAX_STR_LEN > 31) begin : g_len_check
		$error("MAX_STR_LEN must lie in 1..31");
	end

	localparam logic [15:0] LEN_MAX = 16'(MAX_STR_LEN);

	typedef struct packed {
		pdcu_pkg::pdcu_state_t state;
		logic [7:0]            op;
		logic [31:0]           opnd;
		logic [15:0]           len1;
		logic [15:0]           len2;
		logic [31:0]           a1;
		logic [31:0]           a2;
		logic [7:0]            rnd;
		logic                  busy;
		logic                  done;
		logic                  abort;
		logic                  fn;
		logic                  fz;
		logic                  fv;
		logic                  fc;
		logic [31:0]           r1;
		logic [31:0]           r3;
		logic [127:0]          acc1;
		logic [127:0]          acc2;
		logic [4:0]            lcur;
		logic [31:0]           base;
		logic [5:0]            cnt;
		logic [31:0]           bin;
		logic [33:0]           mag;
		logic                  big;
		pdcu_pkg::pdcu_store_t skind;
		logic [127:0]          svec;
		logic [7:0]            sgn_ch;
		logic [5:0]            snb;
		logic                  mem_req;
		logic                  mem_we;
		logic [31:0]           mem_addr;
		logic [7:0]            mem_wdata;
		logic                  dp_wr;
		logic [7:0]            dp_addr;
		logic [31:0]           hrdata;
		logic                  rdy;
	} pdcu_regs_t;

	pdcu_regs_t s_q;
	pdcu_regs_t s_d;

	// digit mask for a string of l digits
	function automatic logic [127:0] dmask(input logic [4:0] l);
		dmask = (128'h1 << {l, 2'b00}) - 128'h1;
	endfunction : dmask

	// digits of a loaded packed string, sign nibble dropped, even-length pad cut
	function automatic logic [127:0] digits(input logic [127:0] acc, input logic [4:0] l);
		digits = (acc >> 4) & dmask(l);
	endfunction : digits

	function automatic logic is_neg(input logic [3:0] sg);
		is_neg = (sg == pdcu_pkg::SIGN_NEG) || (sg == pdcu_pkg::SIGN_NEG_ALT);
	endfunction : is_neg

	function automatic logic [5:0] packed_bytes(input logic [4:0] l);
		packed_bytes = {2'b00, l[4:1]} + 6'h01;
	endfunction : packed_bytes

	// decimal increment, carry ripples through nines
	function automatic logic [127:0] bcd_inc(input logic [127:0] v);
		logic       c;
		logic [3:0] d;
		c = 1'b1;
		bcd_inc = v;
		for (int i = 0; i < 32; i++) begin
			d = v[4*i +: 4];
			if (c) begin
				if (d == 4'h9) begin
					bcd_inc[4*i +: 4] = 4'h0;
				end else begin
					bcd_inc[4*i +: 4] = d + 4'h1;
					c = 1'b0;
				end
			end
		end
	endfunction : bcd_inc

	// add three to every digit of five or more before the dabble shift
	function automatic logic [39:0] dabble_adj(input logic [39:0] v);
		dabble_adj = v;
		for (int i = 0; i < 10; i++) begin
			if (v[4*i +: 4] >= 4'h5) begin
				dabble_adj[4*i +: 4] = v[4*i +: 4] + 4'h3;
			end
		end
	endfunction : dabble_adj

	function automatic logic [7:0] store_byte(input pdcu_pkg::pdcu_store_t k,
		input logic [127:0] v, input logic [7:0] sg, input logic [5:0] nb,
		input logic [5:0] idx);
		logic [127:0] t;
		logic [5:0]   j;
		j = nb - idx - 6'h01;
		t = 128'h0;
		store_byte = 8'h00;
		case (k)
			pdcu_pkg::SK_PACKED: begin
				t = v >> {j, 3'b000};
				store_byte = t[7:0];
			end
			pdcu_pkg::SK_LSEP: begin
				t = v >> {j, 2'b00};
				store_byte = (idx == 6'h00) ? sg : (pdcu_pkg::ASCII_ZERO | {4'h0, t[3:0]});
			end
			pdcu_pkg::SK_LONG: begin
				t = v >> {idx, 3'b000};
				store_byte = t[7:0];
			end
			default: store_byte = 8'h00;
		endcase
	endfunction : store_byte

	function automatic logic [31:0] read_mux(input pdcu_regs_t r, input logic [7:0] a);
		case (a)
			pdcu_pkg::OFS_CMD:    read_mux = {24'h0, r.op};
			pdcu_pkg::OFS_OPND:   read_mux = r.opnd;
			pdcu_pkg::OFS_LENS:   read_mux = {r.len2, r.len1};
			pdcu_pkg::OFS_ADDR1:  read_mux = r.a1;
			pdcu_pkg::OFS_ADDR2:  read_mux = r.a2;
			pdcu_pkg::OFS_ROUND:  read_mux = {24'h0, r.rnd};
			pdcu_pkg::OFS_STATUS: read_mux = {24'h0, r.fn, r.fz, r.fv, r.fc,
				r.fv, r.abort, r.done, r.busy};
			pdcu_pkg::OFS_R0:     read_mux = pdcu_pkg::WORD_RESET;
			pdcu_pkg::OFS_R1:     read_mux = r.r1;
			pdcu_pkg::OFS_R2:     read_mux = pdcu_pkg::WORD_RESET;
			pdcu_pkg::OFS_R3:     read_mux = r.r3;
			default:              read_mux = pdcu_pkg::WORD_RESET;
		endcase
	endfunction : read_mux

	logic [127:0] dig1;
	logic [127:0] dig2;
	logic [127:0] trunc;
	logic [127:0] tmp;
	logic [127:0] st;
	logic [255:0] wide;
	logic [7:0]   sh;
	logic [4:0]   dlen;
	logic [4:0]   len2c;
	logic         sgn1;
	logic         sgn2;
	logic         sgn_res;
	logic         ovf;
	logic         lt;
	logic [37:0]  mg;
	logic [3:0]   dg;
	logic [31:0]  lo;
	logic         last;

	always_comb begin
		s_d = s_q;
		dig1 = digits(s_q.acc1, s_q.len1[4:0]);
		len2c = (s_q.op == pdcu_pkg::OP_CMP_SHARED) ? s_q.len1[4:0] : s_q.len2[4:0];
		dig2 = digits(s_q.acc2, len2c);
		sgn1 = is_neg(s_q.acc1[3:0]) && (dig1 != 128'h0);
		sgn2 = is_neg(s_q.acc2[3:0]) && (dig2 != 128'h0);
		trunc = 128'h0;
		tmp = 128'h0;
		st = 128'h0;
		wide = 256'h0;
		sh = 8'h00;
		dlen = s_q.len2[4:0];
		sgn_res = 1'b0;
		ovf = 1'b0;
		lt = 1'b0;
		mg = 38'h0;
		dg = 4'h0;
		lo = 32'h0;
		last = 1'b0;
		s_d.rdy = 1'b1;

		// data phase of a write; operands frozen while busy
		if (s_q.dp_wr && !s_q.busy) begin
			case (s_q.dp_addr)
				pdcu_pkg::OFS_CMD: begin
					s_d.op = HWDATA_I[7:0];
					if (HWDATA_I[pdcu_pkg::CMD_START_BIT]) begin
						s_d.busy = 1'b1;
						s_d.done = 1'b0;
						s_d.abort = 1'b0;
						s_d.state = pdcu_pkg::ST_CHECK;
					end
				end
				pdcu_pkg::OFS_OPND:  s_d.opnd = HWDATA_I;
				pdcu_pkg::OFS_LENS: begin
					s_d.len1 = HWDATA_I[15:0];
					s_d.len2 = HWDATA_I[31:16];
				end
				pdcu_pkg::OFS_ADDR1: s_d.a1 = HWDATA_I;
				pdcu_pkg::OFS_ADDR2: s_d.a2 = HWDATA_I;
				pdcu_pkg::OFS_ROUND: s_d.rnd = HWDATA_I[7:0];
				default: ;
			endcase
		end

		// address phase; read data is prepared here so the data phase needs no wait
		s_d.dp_wr = 1'b0;
		if (HSEL_I && HREADY_I && HTRANS_I[1]) begin
			s_d.dp_wr = HWRITE_I;
			s_d.dp_addr = HADDR_I[7:0];
			s_d.hrdata = HWRITE_I ? pdcu_pkg::WORD_RESET : read_mux(s_q, HADDR_I[7:0]);
		end

		case (s_q.state)
			pdcu_pkg::ST_IDLE: ;
			pdcu_pkg::ST_CHECK: begin
				s_d.cnt = 6'h00;
				s_d.acc1 = 128'h0;
				s_d.acc2 = 128'h0;
				s_d.bin = 32'h0;
				s_d.mag = 34'h0;
				s_d.big = 1'b0;
				s_d.lcur = s_q.len1[4:0];
				s_d.base = s_q.a1;
				s_d.mem_addr = s_q.a1;
				s_d.mem_we = 1'b0;
				case (s_q.op)
					pdcu_pkg::OP_L2P: begin
						s_d.bin = s_q.opnd[31] ? 32'(-s_q.opnd) : s_q.opnd;
						if (s_q.len2 > LEN_MAX) s_d.abort = 1'b1;
						else s_d.state = pdcu_pkg::ST_CONV;
					end
					pdcu_pkg::OP_CMP_SHARED, pdcu_pkg::OP_P2L: begin
						if (s_q.len1 > LEN_MAX) s_d.abort = 1'b1;
						else s_d.state = pdcu_pkg::ST_LOAD1;
					end
					pdcu_pkg::OP_SHIFT_ROUND, pdcu_pkg::OP_CMP_TWO, pdcu_pkg::OP_P2LS,
					pdcu_pkg::OP_P2T: begin
						if (s_q.len1 > LEN_MAX || s_q.len2 > LEN_MAX) s_d.abort = 1'b1;
						else s_d.state = pdcu_pkg::ST_LOAD1;
					end
					default: s_d.abort = 1'b1;
				endcase
				s_d.mem_req = (s_d.state == pdcu_pkg::ST_LOAD1);
				if (s_d.abort) begin
					s_d.busy = 1'b0;
					s_d.done = 1'b1;
					s_d.state = pdcu_pkg::ST_IDLE;
				end
			end
			// whole source is read before any store, so overlap is harmless
			pdcu_pkg::ST_LOAD1, pdcu_pkg::ST_LOAD2: begin
				if (MEM_ACK_I) begin
					if (s_q.state == pdcu_pkg::ST_LOAD1) s_d.acc1 = {s_q.acc1[119:0], MEM_RDATA_I};
					else s_d.acc2 = {s_q.acc2[119:0], MEM_RDATA_I};
					s_d.cnt = s_q.cnt + 6'h01;
					s_d.mem_addr = s_q.base + 32'(s_d.cnt);
					if (s_d.cnt == packed_bytes(s_q.lcur)) begin
						s_d.mem_req = 1'b0;
						s_d.cnt = 6'h00;
						if (s_q.state == pdcu_pkg::ST_LOAD1 &&
							(s_q.op == pdcu_pkg::OP_CMP_SHARED || s_q.op == pdcu_pkg::OP_CMP_TWO)) begin
							s_d.state = pdcu_pkg::ST_LOAD2;
							s_d.lcur = len2c;
							s_d.base = s_q.a2;
							s_d.mem_addr = s_q.a2;
							s_d.mem_req = 1'b1;
						end else if (s_q.op == pdcu_pkg::OP_P2L) begin
							s_d.state = pdcu_pkg::ST_CONV;
						end else begin
							s_d.state = pdcu_pkg::ST_EXEC;
						end
					end
				end
			end
			pdcu_pkg::ST_CONV: begin
				s_d.cnt = s_q.cnt + 6'h01;
				if (s_q.op == pdcu_pkg::OP_L2P) begin
					// ten digits hold any magnitude up to 2**31, so the bit cut off is always zero
					s_d.acc2[39:0] = 40'({dabble_adj(s_q.acc2[39:0]), s_q.bin[31]});
					s_d.bin = {s_q.bin[30:0], 1'b0};
					last = (s_d.cnt == pdcu_pkg::DABBLE_STEPS);
				end else begin
					// low word kept exactly mod 2**32, magnitude wraps but a sticky big flag records overflow for range check
					tmp = dig1 >> {5'(5'd31 - s_q.cnt[4:0]), 2'b00};
					dg = tmp[3:0];
					s_d.bin = 32'((s_q.bin << 3) + (s_q.bin << 1) + {28'h0, dg});
					mg = {4'h0, s_q.mag} * 38'd10 + {34'h0, dg};
					s_d.big = s_q.big || (mg[37:32] != 6'h00);
					s_d.mag = mg[33:0];
					last = (s_d.cnt == pdcu_pkg::P2L_STEPS);
				end
				if (last) begin
					s_d.cnt = 6'h00;
					s_d.state = pdcu_pkg::ST_EXEC;
				end
			end
			pdcu_pkg::ST_EXEC: begin
				s_d.fc = 1'b0;
				s_d.r1 = s_q.a1;
				s_d.r3 = s_q.a2;
				s_d.state = pdcu_pkg::ST_IDLE;
				s_d.skind = pdcu_pkg::SK_PACKED;
				s_d.snb = packed_bytes(dlen);
				case (s_q.op)
					pdcu_pkg::OP_SHIFT_ROUND, pdcu_pkg::OP_L2P: begin
						if (s_q.op == pdcu_pkg::OP_L2P) begin
							wide = {216'h0, s_q.acc2[39:0]};
							sgn_res = s_q.opnd[31];
							s_d.r1 = pdcu_pkg::WORD_RESET;
						end else begin
							sgn_res = is_neg(s_q.acc1[3:0]);
							if (!s_q.opnd[7]) begin
								wide = {128'h0, dig1} << {s_q.opnd[7:0], 2'b00};
							end else begin
								sh = 8'(-s_q.opnd[7:0]);
								trunc = dig1 >> {sh, 2'b00};
								tmp = dig1 >> 10'({sh, 2'b00} - 10'd4);
								if ({1'b0, tmp[3:0]} + {1'b0, s_q.rnd[3:0]} >= 5'd10) begin
									trunc = bcd_inc(trunc);
								end
								wide = {128'h0, trunc};
							end
						end
						ovf = (wide >> {dlen, 2'b00}) != 256'h0;
						// counts of 32 and up leave no digit in the low 128 bits, so any nonzero source overflows
						if (s_q.op == pdcu_pkg::OP_SHIFT_ROUND && !s_q.opnd[7] &&
							s_q.opnd[6:5] != 2'b00 && dig1 != 128'h0) ovf = 1'b1;
						st = wide[127:0] & dmask(dlen);
						// zero keeps its sign only when digits were lost
						s_d.svec = {st[123:0], (sgn_res && (st != 128'h0 || ovf)) ?
							pdcu_pkg::SIGN_NEG : pdcu_pkg::SIGN_POS};
						s_d.fn = sgn_res && (st != 128'h0);
						s_d.fz = (st == 128'h0);
						s_d.fv = ovf;
						s_d.state = pdcu_pkg::ST_STORE;
					end
					pdcu_pkg::OP_CMP_SHARED, pdcu_pkg::OP_CMP_TWO: begin
						if (sgn1 != sgn2) lt = sgn1;
						else if (!sgn1) lt = dig1 < dig2;
						else lt = dig1 > dig2;
						s_d.fn = lt;
						s_d.fz = (sgn1 == sgn2) && (dig1 == dig2);
						s_d.fv = 1'b0;
					end
					pdcu_pkg::OP_P2L: begin
						lo = is_neg(s_q.acc1[3:0]) ? 32'(-s_q.bin) : s_q.bin;
						if (is_neg(s_q.acc1[3:0])) ovf = s_q.big || (s_q.mag > 34'h0_8000_0000);
						else ovf = s_q.big || (s_q.mag > 34'h0_7FFF_FFFF);
						s_d.fn = lo[31];
						s_d.fz = (lo == 32'h0);
						s_d.fv = ovf;
						s_d.r3 = pdcu_pkg::WORD_RESET;
						s_d.svec = {96'h0, lo};
						s_d.skind = pdcu_pkg::SK_LONG;
						s_d.snb = pdcu_pkg::LONG_BYTES;
						s_d.state = pdcu_pkg::ST_STORE;
					end
					default: begin
						// leading separate and trailing: flags follow the source value
						ovf = (dig1 >> {dlen, 2'b00}) != 128'h0;
						s_d.fn = sgn1;
						s_d.fz = (dig1 == 128'h0);
						s_d.fv = ovf;
						if (s_q.op == pdcu_pkg::OP_P2LS) begin
							s_d.svec = dig1 & dmask(dlen);
							s_d.sgn_ch = sgn1 ? pdcu_pkg::ASCII_MINUS : pdcu_pkg::ASCII_PLUS;
							s_d.skind = pdcu_pkg::SK_LSEP;
							s_d.snb = {1'b0, dlen} + 6'h01;
							s_d.state = pdcu_pkg::ST_STORE;
						end
					end
				endcase
				if (s_d.state == pdcu_pkg::ST_STORE) begin
					s_d.mem_req = 1'b1;
					s_d.mem_we = 1'b1;
					s_d.mem_addr = s_q.a2;
					s_d.mem_wdata = store_byte(s_d.skind, s_d.svec, s_d.sgn_ch, s_d.snb, 6'h00);
				end else begin
					s_d.busy = 1'b0;
					s_d.done = 1'b1;
				end
			end
			pdcu_pkg::ST_STORE: begin
				if (MEM_ACK_I) begin
					s_d.cnt = s_q.cnt + 6'h01;
					s_d.mem_addr = s_q.a2 + 32'(s_d.cnt);
					s_d.mem_wdata = store_byte(s_q.skind, s_q.svec, s_q.sgn_ch, s_q.snb, s_d.cnt);
					if (s_d.cnt == s_q.snb) begin
						s_d.mem_req = 1'b0;
						s_d.mem_we = 1'b0;
						s_d.cnt = 6'h00;
						s_d.busy = 1'b0;
						s_d.done = 1'b1;
						s_d.state = pdcu_pkg::ST_IDLE;
					end
				end
			end
			default: s_d.state = pdcu_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign HRDATA_O     = s_q.hrdata;
	assign HREADYOUT_O  = s_q.rdy;
	assign HRESP_O      = 1'b0;
	assign MEM_REQ_O    = s_q.mem_req;
	assign MEM_WE_O     = s_q.mem_we;
	assign MEM_ADDR_O   = s_q.mem_addr;
	assign MEM_WDATA_O  = s_q.mem_wdata;
	assign BUSY_O       = s_q.busy;
	assign DONE_O       = s_q.done;
	assign RSVD_ABORT_O = s_q.abort;
	assign OVERFLOW_O   = s_q.fv;

endmodule : pdcu_unit

// File: testbench/pdcu_properties.sv
/*
 * Port checker for pdcu_unit, bound to every instance.
 * Assumes HREADY_I is tied to HREADYOUT_O.
 */
`timescale 1ns/100ps
module pdcu_props #(
	parameter int MAX_STR_LEN = 31
) (
	// clock and reset
	input  wire logic        CLK_I,
	input  wire logic        RST_N_I,
	// register bus
	input  wire logic        HSEL_I,
	input  wire logic [31:0] HADDR_I,
	input  wire logic [1:0]  HTRANS_I,
	input  wire logic        HWRITE_I,
	input  wire logic [31:0] HWDATA_I,
	input  wire logic        HREADY_I,
	// memory path
	input  wire logic        MEM_REQ_O,
	input  wire logic        MEM_WE_O,
	input  wire logic [31:0] MEM_ADDR_O,
	input  wire logic [7:0]  MEM_WDATA_O,
	input  wire logic        MEM_ACK_I,
	// status
	input  wire logic        BUSY_O,
	input  wire logic        DONE_O,
	input  wire logic        RSVD_ABORT_O
);
	logic       dp_q;
	logic [7:0] op_q;
	logic       go;
	logic       st;
	logic       cmp;

	assign go = dp_q && HREADY_I && HWDATA_I[8] && !BUSY_O;
	assign st = BUSY_O && MEM_REQ_O && MEM_WE_O;
	assign cmp = op_q == pdcu_pkg::OP_CMP_SHARED || op_q == pdcu_pkg::OP_CMP_TWO;

	// opcode of the running instruction, taken from the command write
	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			dp_q <= 1'b0;
			op_q <= 8'h00;
		end else begin
			if (HREADY_I)
				dp_q <= HSEL_I && HTRANS_I[1] && HWRITE_I && HADDR_I[7:0] == 8'h00;
			if (go)
				op_q <= HWDATA_I[7:0];
		end
	end

	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (!RST_N_I);

	sequence s_start;
		go;
	endsequence
	sequence s_wait;
		MEM_REQ_O && !MEM_ACK_I;
	endsequence

	a_start_busy: assert property (s_start |=> BUSY_O)
		else $error("no busy after start");
	a_req_held: assert property (s_wait |=> MEM_REQ_O && $stable(MEM_ADDR_O)
		&& $stable(MEM_WE_O) && $stable(MEM_WDATA_O))
		else $error("request changed before ack");
	a_done_at_end: assert property ($fell(BUSY_O) |-> DONE_O && !MEM_REQ_O)
		else $error("busy fell without done");
	a_done_cleared: assert property ($rose(BUSY_O) |-> !DONE_O)
		else $error("done kept at start");
	a_cmp_no_store: assert property (cmp |-> !st)
		else $error("compare wrote memory");
	a_p2t_no_store: assert property (op_q == pdcu_pkg::OP_P2T |-> !st)
		else $error("trailing convert wrote memory");
	a_l2p_no_read: assert property (op_q == pdcu_pkg::OP_L2P && BUSY_O && MEM_REQ_O
		|-> MEM_WE_O)
		else $error("long to packed read memory");
	a_abort_quiet: assert property ($rose(RSVD_ABORT_O) |-> DONE_O && !BUSY_O
		&& !$past(MEM_REQ_O) && !$past(MEM_REQ_O, 2))
		else $error("abort with memory access");
endmodule : pdcu_props

bind pdcu_unit pdcu_props #(.MAX_STR_LEN(MAX_STR_LEN)) pdcu_props_inst (.CLK_I, .RST_N_I,
	.HSEL_I, .HADDR_I, .HTRANS_I, .HWRITE_I, .HWDATA_I, .HREADY_I, .MEM_REQ_O, .MEM_WE_O,
	.MEM_ADDR_O, .MEM_WDATA_O, .MEM_ACK_I, .BUSY_O, .DONE_O, .RSVD_ABORT_O);

// File: testbench/pdcu_mem.sv
/*
 * Byte memory holding decimal string operands.
 * Answers a held request after dly_i waiting cycles with a one-cycle ack.
 */
`timescale 1ns/100ps
module pdcu_mem (
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	// request
	input  wire logic        req_i,
	input  wire logic        we_i,
	input  wire logic [31:0] addr_i,
	input  wire logic [7:0]  wdata_i,
	input  wire logic [3:0]  dly_i,
	// answer
	output logic      [7:0]  rdata_o,
	output logic             ack_o
);
	logic [7:0] mem [256];
	logic [3:0] cnt;
	int         n_rd = 0;
	int         n_wr = 0;

	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ack_o <= 1'b0;
			cnt <= 4'h0;
			rdata_o <= 8'h00;
		end else if (req_i && !ack_o && cnt >= dly_i) begin
			ack_o <= 1'b1;
			cnt <= 4'h0;
			if (we_i) begin
				mem[addr_i[7:0]] <= wdata_i;
				n_wr <= n_wr + 1;
			end else begin
				rdata_o <= mem[addr_i[7:0]];
				n_rd <= n_rd + 1;
			end
		end else begin
			// stale data must not look valid outside the ack cycle
			ack_o <= 1'b0;
			rdata_o <= ~rdata_o;
			cnt <= (req_i && !ack_o) ? cnt + 4'h1 : 4'h0;
		end
	end
endmodule : pdcu_mem

// File: testbench/test_packed_decimal_convert_unit.sv
/*
 * Self-checking bench for pdcu_unit: AHB-Lite master tasks, one task per scenario.
 * Assumes pdcu_mem and the checker are compiled before this file.
 */
`timescale 1ns/100ps
module test_packed_decimal_convert_unit;
	logic        clk;
	logic        rst_n = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic        hready;
	logic        mreq, mwe, mack, busy, done, abrt, ovf, hresp;
	logic [31:0] maddr;
	logic [7:0]  mwdata, mrdata;
	logic [3:0]  dly = 4'h0;
	int          error_cnt = 0;
	int          check_count = 0;
	int          cyc = 0;

	pdcu_unit pdcu_unit_inst (.CLK_I(clk), .RST_N_I(rst_n), .HSEL_I(1'b1), .HADDR_I(haddr),
		.HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata),
		.HREADY_I(hready), .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(hresp),
		.MEM_REQ_O(mreq), .MEM_WE_O(mwe), .MEM_ADDR_O(maddr), .MEM_WDATA_O(mwdata),
		.MEM_RDATA_I(mrdata), .MEM_ACK_I(mack), .BUSY_O(busy), .DONE_O(done),
		.RSVD_ABORT_O(abrt), .OVERFLOW_O(ovf));
	pdcu_mem pdcu_mem_inst (.clk_i(clk), .rst_n_i(rst_n), .req_i(mreq), .we_i(mwe),
		.addr_i(maddr), .wdata_i(mwdata), .dly_i(dly), .rdata_o(mrdata), .ack_o(mack));

	task automatic finish_test;
		$display("errors %0d checks %0d", error_cnt, check_count);
		if (error_cnt == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : finish_test

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask : chk

	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		haddr <= {24'h000000, a};
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge clk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hready !== 1'b1);
		q = hrdata;
		chk({31'h0, hresp}, 32'h0);
	endtask : bus

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		chk(q, e);
	endtask : rd

	task automatic put(input logic [7:0] a, input logic [7:0] b[$]);
		foreach (b[i]) pdcu_mem_inst.mem[a + i] = b[i];
	endtask : put

	task automatic mchk(input logic [7:0] a, input logic [7:0] b[$]);
		foreach (b[i]) chk({24'h0, pdcu_mem_inst.mem[a + i]}, {24'h0, b[i]});
	endtask : mchk

	task automatic run(input logic [7:0] op, input logic [31:0] lens, a1, a2, opnd, rnd);
		int n;
		wr(8'h08, lens);
		wr(8'h0C, a1);
		wr(8'h10, a2);
		wr(8'h04, opnd);
		wr(8'h14, rnd);
		wr(8'h00, {23'h0, 1'b1, op});
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (done !== 1'b1 && n < 3000);
		chk(n < 3000, 32'h1);
	endtask : run

	// status word: nzvc, overflow, abort, done set, busy clear
	task automatic regs(input logic [3:0] f, input logic ab, input logic [31:0] r1, r3);
		rd(8'h18, {24'h0, f, f[1], ab, 2'h2});
		chk({31'h0, ovf}, {31'h0, f[1]});
		rd(8'h1C, 32'h0);
		rd(8'h20, r1);
		rd(8'h24, 32'h0);
		rd(8'h28, r3);
	endtask : regs

	task automatic t_cmp;
		int w;
		w = pdcu_mem_inst.n_wr;
		dly <= 4'h3;
		put(8'h20, '{8'h0C});
		put(8'h30, '{8'h0D});
		run(8'h35, 32'h0, 32'h20, 32'h30, 32'h0, 32'h0);
		regs(4'h4, 1'b0, 32'h20, 32'h30);
		put(8'h20, '{8'h5D});
		put(8'h30, '{8'h01, 8'h2C});
		run(8'h37, 32'h0002_0001, 32'h20, 32'h30, 32'h0, 32'h0);
		regs(4'h8, 1'b0, 32'h20, 32'h30);
		chk(pdcu_mem_inst.n_wr - w, 32'h0);
		dly <= 4'h0;
	endtask : t_cmp

	task automatic t_shift;
		logic [7:0]  c [6] = '{8'hFF, 8'hFF, 8'h00, 8'h01, 8'hFF, 8'h40};
		logic [7:0]  r [6] = '{8'h05, 8'h00, 8'h05, 8'h05, 8'h05, 8'h00};
		logic [7:0]  s [6] = '{8'h5C, 8'h5C, 8'h5C, 8'h5C, 8'h5D, 8'h5C};
		logic [23:0] e [6] = '{24'h00013C, 24'h00012C, 24'h00125C, 24'h01250C, 24'h00013D,
			24'h00000C};
		logic [3:0]  f [6] = '{4'h0, 4'h0, 4'h0, 4'h0, 4'h8, 4'h6};
		for (int i = 0; i < 6; i++) begin
			put(8'h20, '{8'h12, s[i]});
			put(8'h40, '{8'hEE, 8'hEE, 8'hEE});
			run(8'hF8, 32'h0005_0003, 32'h20, 32'h40, {24'h0, c[i]}, {24'h0, r[i]});
			mchk(8'h40, '{e[i][23:16], e[i][15:8], e[i][7:0]});
			regs(f[i], 1'b0, 32'h20, 32'h40);
		end
	endtask : t_shift

	task automatic t_l2p;
		logic [15:0] e;
		for (int i = 0; i < 2; i++) begin
			e = i ? 16'h023C : 16'h042D;
			put(8'h50, '{8'hEE, 8'hEE});
			run(8'hF9, 32'h0002_0000, 32'h20, 32'h50, i ? 32'h7B : 32'hFFFF_FFD6, 32'h0);
			mchk(8'h50, '{e[15:8], e[7:0]});
			regs(i ? 4'h2 : 4'h8, 1'b0, 32'h0, 32'h50);
		end
	endtask : t_l2p

	task automatic t_p2l;
		dly <= 4'h2;
		put(8'h20, '{8'h12, 8'h3D});
		run(8'h36, 32'h3, 32'h20, 32'h20, 32'h0, 32'h0);
		mchk(8'h20, '{8'h85, 8'hFF, 8'hFF, 8'hFF});
		regs(4'h8, 1'b0, 32'h20, 32'h0);
		put(8'h20, '{8'h09, 8'h99, 8'h99, 8'h99, 8'h99, 8'h9C});
		run(8'h36, 32'hA, 32'h20, 32'h60, 32'h0, 32'h0);
		mchk(8'h60, '{8'hFF, 8'hE3, 8'h0B, 8'h54});
		regs(4'h2, 1'b0, 32'h20, 32'h0);
		dly <= 4'h0;
	endtask : t_p2l

	task automatic t_p2s;
		put(8'h20, '{8'h0D});
		put(8'h70, '{8'hEE, 8'hEE, 8'hEE});
		run(8'h08, 32'h0001_0001, 32'h20, 32'h70, 32'h0, 32'h0);
		mchk(8'h70, '{8'h2B, 8'h30});
		regs(4'h4, 1'b0, 32'h20, 32'h70);
		put(8'h20, '{8'h7D});
		run(8'h08, 32'h0002_0001, 32'h20, 32'h70, 32'h0, 32'h0);
		mchk(8'h70, '{8'h2D, 8'h30, 8'h37});
		regs(4'h8, 1'b0, 32'h20, 32'h70);
		put(8'h20, '{8'h05, 8'h0C});
		put(8'h70, '{8'hEE, 8'hEE, 8'hEE});
		run(8'h08, 32'h0001_0002, 32'h20, 32'h70, 32'h0, 32'h0);
		mchk(8'h70, '{8'h2B, 8'h30});
		regs(4'h2, 1'b0, 32'h20, 32'h70);
	endtask : t_p2s

	task automatic t_p2t;
		int w;
		w = pdcu_mem_inst.n_wr;
		put(8'h20, '{8'h3D});
		run(8'h24, 32'h0001_0001, 32'h20, 32'h70, 32'h0, 32'h0);
		regs(4'h8, 1'b0, 32'h20, 32'h70);
		chk(pdcu_mem_inst.n_wr - w, 32'h0);
	endtask : t_p2t

	// flags and registers are expected to survive an abort unchanged
	task automatic t_abort;
		int n;
		n = pdcu_mem_inst.n_rd;
		run(8'h35, 32'h20, 32'h30, 32'h40, 32'h0, 32'h0);
		chk(abrt, 32'h1);
		chk(pdcu_mem_inst.n_rd - n, 32'h0);
		regs(4'h8, 1'b1, 32'h20, 32'h70);
		rd(8'h3C, 32'h0);
		wr(8'h3C, 32'hFFFF_FFFF);
		rd(8'h3C, 32'h0);
	endtask : t_abort

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	always @(posedge clk) cyc <= cyc + 1;

	initial begin
		wait (cyc == 20000);
		error_cnt++;
		finish_test();
	end

	initial begin
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk);
		t_cmp();
		t_shift();
		t_l2p();
		t_p2l();
		t_p2s();
		t_p2t();
		t_abort();
		finish_test();
	end
endmodule : test_packed_decimal_convert_unit
